//--- hdl/tpat_timer.sv
// thermal pin assertion timer with limit compare and overtemp-time flag
// Summary of operation
// - upper seven status bits read zero until assertion exceeds 45.52 ms
// - status bit 0 sets on pin assertion and clears on status read
// - past 45.52 ms bit 0 becomes lsb of the 8-bit elapsed count
// - one count step equals 22.76 ms, covering 45.52 ms to 5.80 s
// - fully writable 8-bit limit register compared against the count
// - count above limit sets overtemp-time flag, bit 5 of register 0x42
// - limit 0x00 sets the overtemp-time flag as soon as pin asserts
// - status and limit registers are 0x00 after reset
// - with all limit output enables zero the pin is never driven
`include "tpat_consts.svh"

module tpat_timer
  import tpat_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `TPAT_STEP_CYCLES
) (
  // clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  // register port from the serial management interface
  input  wire tpat_reg_req_t   i_reg_req,
  output logic [7:0]           o_reg_rdata,
  // thermal alert pin, active low, open drain
  input  wire logic            i_thermal_alert_pin_n,
  output tpat_pin_drive_t      o_thermal_alert_pin,
  // per-channel limit output enables and overtemp request
  input  wire logic [2:0]      i_limit_output_enable,
  input  wire logic            i_overtemp_drive_req,
  // status for the rest of the device
  output logic                 o_overtemp_time_exceeded_flag
);

  localparam int unsigned STEP_W = $clog2(STEP_CYCLES + 1);

  logic              pin_asserted;
  logic              pin_asserted_q;
  logic              assert_edge;
  logic [STEP_W-1:0] step_cnt;
  logic              step_tick;
  logic [7:0]        assertion_time_count;
  logic              assert_flag;
  logic [7:0]        assertion_time_limit;
  logic              overtemp_time_exceeded_flag;
  logic              rd_status;
  logic              rd_int2;
  logic              exceeded;
  logic [7:0]        status_view;
  logic [7:0]        next_rdata;

  assign pin_asserted = ~i_thermal_alert_pin_n;
  assign assert_edge  = pin_asserted & ~pin_asserted_q;
  assign rd_status = i_reg_req.rd && (i_reg_req.addr == `TPAT_OFS_TIME_STATUS);
  assign rd_int2   = i_reg_req.rd && (i_reg_req.addr == `TPAT_OFS_INT_STATUS2);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_asserted_q <= 1'b0;
    end else begin
      pin_asserted_q <= pin_asserted;
    end
  end

  // prescaler restarts whenever the pin releases so steps align to assertion
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_cnt <= '0;
    end else if (!pin_asserted || step_tick) begin
      step_cnt <= '0;
    end else begin
      step_cnt <= step_cnt + STEP_W'(1);
    end
  end

  assign step_tick = pin_asserted && (step_cnt == STEP_W'(STEP_CYCLES - 1));

  // elapsed count accumulates over assertions until software reads it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      assertion_time_count <= `TPAT_RST_TIME_STATUS;
    end else if (rd_status) begin
      assertion_time_count <= 8'h00;
    end else if (step_tick && assertion_time_count != `TPAT_COUNT_MAX) begin
      assertion_time_count <= assertion_time_count + 8'h01;
    end
  end

  // set wins over the clearing read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      assert_flag <= 1'b0;
    end else if (assert_edge) begin
      assert_flag <= 1'b1;
    end else if (rd_status) begin
      assert_flag <= 1'b0;
    end
  end

  // low count hides the timer field; beyond it the raw count shows
  always_comb begin
    if (assertion_time_count >= `TPAT_COUNT_VISIBLE) begin
      status_view = assertion_time_count;
    end else begin
      status_view = {7'h00, assert_flag};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      assertion_time_limit <= `TPAT_RST_TIME_LIMIT;
    end else if (i_reg_req.wr &&
                 i_reg_req.addr == `TPAT_OFS_TIME_LIMIT) begin
      assertion_time_limit <= i_reg_req.wdata;
    end
  end

  assign exceeded = (pin_asserted &&
                     assertion_time_limit == `TPAT_LIMIT_IMMEDIATE) ||
                    (assertion_time_count > assertion_time_limit);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overtemp_time_exceeded_flag <= 1'b0;
    end else if (exceeded) begin
      overtemp_time_exceeded_flag <= 1'b1;
    end else if (rd_int2) begin
      overtemp_time_exceeded_flag <= 1'b0;
    end
  end

  assign o_overtemp_time_exceeded_flag = overtemp_time_exceeded_flag;

  // read data is registered; it shows one cycle after the read strobe
  always_comb begin
    next_rdata = 8'h00;
    case (i_reg_req.addr)
      `TPAT_OFS_TIME_STATUS: begin
        next_rdata = status_view;
      end
      `TPAT_OFS_TIME_LIMIT: begin
        next_rdata = assertion_time_limit;
      end
      `TPAT_OFS_INT_STATUS2: begin
        next_rdata[`TPAT_BIT_OVERTEMP_TIME] = overtemp_time_exceeded_flag;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_req.rd) begin
      o_reg_rdata <= next_rdata;
    end
  end

  // pin only pulls low; timer-input-only mode when no channel enables it
  always_comb begin
    o_thermal_alert_pin.pin_o  = 1'b0;
    o_thermal_alert_pin.pin_oe = (|i_limit_output_enable) &&
                                 i_overtemp_drive_req;
  end

  // checked at the read port, not on status_view, so the mux is covered
  property p_upper_zero;
    @(posedge i_clk) disable iff (!i_rst_n)
      (rd_status && assertion_time_count < `TPAT_COUNT_VISIBLE) |=>
        (o_reg_rdata[7:1] == 7'h00);
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("status upper bits nonzero before 45.52 ms");

  property p_flag_set;
    @(posedge i_clk) disable iff (!i_rst_n)
      assert_edge |=> assert_flag;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("assert flag not set on pin assertion");

  property p_flag_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
      (rd_status && !assert_edge) |=> !assert_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("assert flag not cleared by status read");

  property p_view_count;
    @(posedge i_clk) disable iff (!i_rst_n)
      (rd_status && assertion_time_count >= `TPAT_COUNT_VISIBLE) |=>
        (o_reg_rdata == $past(assertion_time_count));
  endproperty
  a_view_count: assert property (p_view_count)
    else $error("status does not show count past threshold");

  property p_step;
    @(posedge i_clk) disable iff (!i_rst_n)
      (step_tick && !rd_status && assertion_time_count != 8'hFF) |=>
        (assertion_time_count == $past(assertion_time_count) + 8'h01);
  endproperty
  a_step: assert property (p_step)
    else $error("count did not advance on step");

  property p_limit_wr;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_reg_req.wr && i_reg_req.addr == `TPAT_OFS_TIME_LIMIT) |=>
        (assertion_time_limit == $past(i_reg_req.wdata));
  endproperty
  a_limit_wr: assert property (p_limit_wr)
    else $error("limit register write lost");

  property p_exceed;
    @(posedge i_clk) disable iff (!i_rst_n)
      (assertion_time_count > assertion_time_limit) |=>
        overtemp_time_exceeded_flag;
  endproperty
  a_exceed: assert property (p_exceed)
    else $error("overtemp-time flag not set above limit");

  property p_immediate;
    @(posedge i_clk) disable iff (!i_rst_n)
      (pin_asserted && assertion_time_limit == 8'h00) |=>
        overtemp_time_exceeded_flag;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("zero limit did not flag at once");

  property p_no_drive;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_limit_output_enable == 3'h0) |-> !o_thermal_alert_pin.pin_oe;
  endproperty
  a_no_drive: assert property (p_no_drive)
    else $error("pin driven while timer-input only");

  property p_saturate;
    @(posedge i_clk) disable iff (!i_rst_n)
      (assertion_time_count == 8'hFF && !rd_status) |=>
        (assertion_time_count == 8'hFF);
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("count wrapped instead of saturating");

  property p_read_clear;
    @(posedge i_clk) disable iff (!i_rst_n)
      rd_status |=> (assertion_time_count == 8'h00);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear count");

endmodule

//--- include/tpat_consts.svh
// constants for the thermal pin assertion timer
`ifndef TPAT_CONSTS_SVH
`define TPAT_CONSTS_SVH

// register offsets
`define TPAT_OFS_INT_STATUS2      8'h42
`define TPAT_OFS_TIME_STATUS      8'h79
`define TPAT_OFS_TIME_LIMIT       8'h7A

// field positions
`define TPAT_BIT_FLAG_LSB         0
`define TPAT_BIT_OVERTEMP_TIME    5

// reset values and the limit value that flags at once
`define TPAT_RST_TIME_STATUS      8'h00
`define TPAT_RST_TIME_LIMIT       8'h00
`define TPAT_LIMIT_IMMEDIATE      8'h00

// timing: clock period and one count step, both in ns
`define TPAT_CLK_PERIOD_NS        10
`define TPAT_STEP_NS              22760000
`define TPAT_STEP_CYCLES          (`TPAT_STEP_NS / `TPAT_CLK_PERIOD_NS)
// count value at which the timer field takes over (45.52 ms)
`define TPAT_COUNT_VISIBLE        8'h02
`define TPAT_COUNT_MAX            8'hFF

`endif

//--- include/tpat_pkg.sv
// types for the thermal pin assertion timer
package tpat_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tpat_reg_req_t;

  typedef struct packed {
    logic pin_o;
    logic pin_oe;
  } tpat_pin_drive_t;

endpackage

//--- testbench/tpat_pin_partner.sv
// external open-drain driver model on the thermal alert line
module tpat_pin_partner
  import tpat_pkg::*;
(
  // pull request from the bench
  input  wire logic            i_pull,
  // device side open-drain drive
  input  wire tpat_pin_drive_t i_dev,
  // resolved line level, active low
  output logic                 o_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // wired-and with pull-up: a released line reads high, never stale
  assign o_pin_n = !(i_pull || (i_dev.pin_oe && !i_dev.pin_o));
endmodule

//--- testbench/thermal_pin_assertion_timer_test.sv
// self-checking bench for the thermal pin assertion timer
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module thermal_pin_assertion_timer_test import tpat_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // short step keeps the saturation run to a few thousand cycles
  localparam int STEP = 10;
  logic            i_clk      = 1'b0;
  logic            i_rst_n    = 1'b0;
  tpat_reg_req_t   req        = '0;
  logic [7:0]      rdata;
  logic            pull       = 1'b0;
  logic            pin_n;
  tpat_pin_drive_t drv;
  logic [2:0]      en         = 3'h0;
  logic            ot_req     = 1'b0;
  logic            flag;
  int              mismatches = 0;
  int              num_checks = 0;
  int              cycles     = 0;
  logic [7:0]      lim;

  always #5 i_clk = ~i_clk;

  tpat_timer #(.STEP_CYCLES(STEP)) u_dut (
    .i_clk                         (i_clk),
    .i_rst_n                       (i_rst_n),
    .i_reg_req                     (req),
    .o_reg_rdata                   (rdata),
    .i_thermal_alert_pin_n         (pin_n),
    .o_thermal_alert_pin           (drv),
    .i_limit_output_enable         (en),
    .i_overtemp_drive_req          (ot_req),
    .o_overtemp_time_exceeded_flag (flag)
  );

  tpat_pin_partner u_partner (.i_pull(pull), .i_dev(drv), .o_pin_n(pin_n));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk) #1 req.wr = 1'b0;
    // idle edge so the next call never retimes req in this step
    @(posedge i_clk) #1;
  endtask

  // data lands on the strobe edge and then stands for the check one edge later
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk) #1 req.rd = 1'b0;
    @(posedge i_clk) #1 `CHK(rdata, e)
  endtask

  // partial steps are lost on release, so 3 spare cycles are harmless
  task automatic hold(input int cyc);
    pull = 1'b1;
    repeat (cyc) @(posedge i_clk);
    #1 pull = 1'b0;
  endtask

  function automatic logic [7:0] exp_status(input int steps);
    if (steps > 255) return 8'hFF;
    return (steps < 2) ? 8'h01 : 8'(steps);
  endfunction

  initial begin
    int steps[4];
    void'($urandom(32'hB5EBAB81));
    steps = '{1, 2, 3 + $urandom_range(17), 300};
    repeat (10) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    chk_rd(8'h79, 8'h00);
    chk_rd(8'h7A, 8'h00);
    chk_rd(8'h33, 8'h00);
    lim = 8'($urandom);
    wr(8'h7A, lim);
    wr(8'h79, 8'h5A);
    chk_rd(8'h7A, lim);
    chk_rd(8'h79, 8'h00);
    wr(8'h7A, 8'hFF);
    foreach (steps[i]) begin
      hold(steps[i] * STEP + 3);
      chk_rd(8'h79, exp_status(steps[i]));
      chk_rd(8'h79, 8'h00);
    end
    lim = 8'(2 + $urandom_range(8));
    wr(8'h7A, lim);
    chk_rd(8'h42, 8'h00);
    pull = 1'b1;
    repeat (lim * STEP + 3) @(posedge i_clk);
    #1 `CHK(flag, 1'b0)
    repeat (STEP) @(posedge i_clk);
    #1 `CHK(flag, 1'b1)
    pull = 1'b0;
    chk_rd(8'h79, lim + 8'h01);
    chk_rd(8'h42, 8'h20);
    chk_rd(8'h42, 8'h00);
    wr(8'h7A, 8'h00);
    hold(3);
    `CHK(flag, 1'b1)
    wr(8'h7A, 8'hFF);
    chk_rd(8'h79, 8'h01);
    chk_rd(8'h42, 8'h20);
    i_rst_n = 1'b0;
    repeat (2) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    `CHK(flag, 1'b0)
    chk_rd(8'h7A, 8'h00);
    chk_rd(8'h79, 8'h00);
    for (int i = 0; i < 16; i++) begin
      en = i[2:0];
      ot_req = i[3];
      @(posedge i_clk) #1 `CHK(drv.pin_oe, (i[2:0] != 0) && i[3])
      `CHK(drv.pin_o, 1'b0)
    end
    print_verdict();
  end
endmodule
